// >>> hdl/ptsp_target.sv
// Expansion-bus target: decode, handshake, byte lanes, parity checking and
// error reporting on the parity-error and system-error lines.
// Assumes pads outside resolve enables into wires, pull-ups on shared lines.
//
// Overview of operation
// RQ1: Shared lines driven high one clock, then released
// RQ2: Another driver waits one idle cycle after release
// RQ3: Bus controller pull-up holds shared lines inactive
// RQ4: Parity-error line low two clocks after error
// RQ5: Data parity errors to parity line, special to system
// RQ6: Parity status only after claim and completed phase
// RQ7: Address and special-cycle parity errors raise system error
// RQ8: System error driven low exactly one clock
// RQ9: System error released, never driven high
// RQ10: Shared address/data lines, address then data phases
// RQ11: Address and command taken when frame first asserted
// RQ12: I/O byte addresses, memory/configuration DWORD addresses
// RQ13: Write data valid with initiator, read with target
// RQ14: Word moves only when both ready lines asserted
// RQ15: Least significant byte on lines 0 to 7
// RQ16: Claim and complete I/O reads and writes
// RQ17: Ignore interrupt acknowledge, special cycle, reserved 0100
// RQ18: Claim memory reads and writes in window
// RQ19: Claim configuration accesses when device select input high
// RQ20: Even parity, valid one clock after phase
// RQ21: Sample all bus inputs on rising clock edge
// RQ22: Check parity on address and completed write phases
`timescale 1ns/100ps
`include "ptsp_defines.svh"

module ptsp_target
  import ptsp_pkg::*;
#(
  parameter logic [31:0] IO_BASE  = 32'h0000_03c0,
  parameter logic [31:0] IO_MASK  = 32'hffff_fff0,
  parameter logic [31:0] MEM_BASE = 32'hf000_0000,
  parameter logic [31:0] MEM_MASK = 32'hff00_0000
)(
  // Clock, reset, enable
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  // Bus side
  input  wire ptsp_bus_in_t  busIn,
  output      ptsp_bus_out_t busOut,
  // User read port, data expected in the cycle of the request
  output      logic          rdReq,
  output      logic [31:0]   rdAddr,
  output      logic [3:0]    rdCmd,
  input  wire logic [31:0]   rdData,
  // User write port
  output      ptsp_wr_t      wrOut
);

  ptsp_state_t s;
  ptsp_state_t next_s;
  logic        addrPhase;
  logic        claim;
  logic        inPar;

  // Address phase: first cycle frame is seen low while idle
  assign addrPhase = ce && (s.step == PTSP_IDLE) && !busIn.frameN && s.frameQ; // see RQ11
  assign inPar     = ^{busIn.ad, busIn.cbeN}; // see RQ20

  // Decode: I/O by byte address, memory and configuration by DWORD
  always_comb
  begin
    claim = 1'b0;
    unique case (busIn.cbeN)
      `PTSP_CMD_IORD, `PTSP_CMD_IOWR:
        claim = (busIn.ad & IO_MASK) == IO_BASE; // see RQ12 see RQ16
      `PTSP_CMD_MEMRD, `PTSP_CMD_MEMWR:
        claim = (busIn.ad[31:2] & MEM_MASK[31:2]) == MEM_BASE[31:2]; // see RQ18
      `PTSP_CMD_CFGRD, `PTSP_CMD_CFGWR:
        claim = busIn.idsel && (busIn.ad[1:0] == `PTSP_CFG_TYPE0); // see RQ19
      default:
        claim = 1'b0; // see RQ17
    endcase
  end

  // Next-state logic for the whole target
  always_comb
  begin
    next_s           = s;
    next_s.frameQ    = busIn.frameN; // see RQ21
    next_s.wr.strobe = 1'b0;
    next_s.serrOe    = 1'b0;
    next_s.chkAddr   = 1'b0;
    next_s.chkData   = 1'b0;
    next_s.chkSpec   = 1'b0;
    // Read parity trails the data lines by one clock
    next_s.parOe     = s.adOe; // see RQ20
    next_s.parOut    = ^{s.adOut, busIn.cbeN};

    // Parity-error line: low, high one clock, released
    unique case (s.perr)
      PTSP_PERR_LOW:  next_s.perr = PTSP_PERR_HIGH; // see RQ1
      PTSP_PERR_HIGH: next_s.perr = PTSP_PERR_OFF;
      default:        next_s.perr = PTSP_PERR_OFF;
    endcase
    if (s.chkData && (busIn.par != s.calcPar))
      next_s.perr = PTSP_PERR_LOW; // see RQ4 see RQ5 see RQ6
    // System error one-clock pulses
    if ((s.chkAddr || s.chkSpec) && (busIn.par != s.calcPar))
      next_s.serrOe = 1'b1; // see RQ7 see RQ8

    // Special cycles are watched, never claimed
    if (s.special && !busIn.irdyN)
    begin
      next_s.chkSpec = 1'b1; // see RQ5
      next_s.calcPar = inPar;
      if (busIn.frameN)
        next_s.special = 1'b0;
    end

    unique case (s.step)
      PTSP_IDLE:
      begin
        if (addrPhase)
        begin
          next_s.chkAddr = 1'b1; // see RQ22
          next_s.calcPar = inPar;
          next_s.addr    = busIn.ad; // see RQ10 see RQ11
          next_s.cmd     = busIn.cbeN;
          next_s.special = busIn.cbeN == `PTSP_CMD_SPECIAL;
          next_s.isRead  = !busIn.cbeN[0];
          if (claim)
          begin
            next_s.step    = PTSP_DATA;
            next_s.devselN = 1'b0;
            next_s.ctlOe   = 1'b1;
            next_s.ready   = 1'b0;
          end
        end
      end
      PTSP_DATA:
      begin
        if (!s.ready)
        begin
          // Fetch phase; read data loaded on the same clock as the target signals ready
          next_s.ready = 1'b1;
          next_s.trdyN = 1'b0;
          if (s.isRead)
          begin
            next_s.adOut = rdData; // see RQ13 see RQ15
            next_s.adOe  = 1'b1;
          end
        end
        else if (!busIn.irdyN)
        begin
          // Both ready lines low: the word moves
          next_s.ready = 1'b0; // see RQ14
          next_s.trdyN = 1'b1;
          next_s.addr  = s.addr + `PTSP_ADDR_STEP;
          if (!s.isRead)
          begin
            next_s.wr.strobe = 1'b1; // see RQ13
            next_s.wr.addr   = s.addr;
            next_s.wr.data   = busIn.ad; // see RQ15
            next_s.wr.be     = ~busIn.cbeN;
            next_s.wr.cmd    = s.cmd;
            next_s.chkData   = 1'b1; // see RQ22
            next_s.calcPar   = inPar;
          end
          if (busIn.frameN)
          begin
            next_s.step    = PTSP_TURN;
            next_s.devselN = 1'b1; // see RQ1
            next_s.adOe    = 1'b0;
          end
        end
      end
      PTSP_TURN:
      begin
        // Control lines were high for one clock; release them
        next_s.step  = PTSP_IDLE; // see RQ1 see RQ2
        next_s.ctlOe = 1'b0;
      end
      default:
      begin
        next_s.step  = PTSP_IDLE;
        next_s.ctlOe = 1'b0;
        next_s.adOe  = 1'b0;
      end
    endcase
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s         <= '0;
      s.step    <= PTSP_IDLE;
      s.perr    <= PTSP_PERR_OFF;
      s.frameQ  <= `PTSP_RST_HIGH;
      s.trdyN   <= `PTSP_RST_HIGH;
      s.devselN <= `PTSP_RST_HIGH;
      s.adOut   <= `PTSP_RST_WORD;
    end
    else if (ce)
      s <= next_s;
  end

  // Output wiring from state flops
  always_comb
  begin
    busOut.ad      = s.adOut;
    busOut.adOe    = s.adOe;
    busOut.par     = s.parOut;
    busOut.parOe   = s.parOe;
    busOut.trdyN   = s.trdyN;
    busOut.devselN = s.devselN;
    busOut.stopN   = `PTSP_RST_HIGH;
    busOut.ctlOe   = s.ctlOe;
    busOut.perrN   = s.perr != PTSP_PERR_LOW;
    busOut.perrOe  = s.perr != PTSP_PERR_OFF;
    busOut.serrN   = `PTSP_RST_LOW; // see RQ9
    busOut.serrOe  = s.serrOe;
  end

  // User read request while fetching
  assign rdReq  = (s.step == PTSP_DATA) && !s.ready && s.isRead;
  assign rdAddr = s.addr;
  assign rdCmd  = s.cmd;
  assign wrOut  = s.wr;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);

  sequence sWrDone;
    (s.step == PTSP_DATA) && s.ready && !busIn.irdyN && !s.isRead;
  endsequence
  sequence sPerrFrame;
    busOut.perrOe && !busOut.perrN ##1 busOut.perrOe && busOut.perrN;
  endsequence

  a_perr_two_clk: assert property (sWrDone ##1 (busIn.par != $past(inPar)) // see RQ4
    |=> sPerrFrame) else $error("parity error not reported two clocks after data");
  a_perr_after_claim: assert property (busOut.perrOe && !busOut.perrN // see RQ6
    |-> $past(wrOut.strobe)) else $error("parity error without completed write");
  a_serr_addr: assert property (addrPhase ##1 (busIn.par != $past(inPar)) // see RQ7
    |=> busOut.serrOe && !busOut.serrN) else $error("address parity error not flagged");
  a_serr_never_high: assert property (busOut.serrOe |-> !busOut.serrN) // see RQ9
    else $error("system error driven high");
  a_ctl_release: assert property (busOut.ctlOe && $rose(busOut.devselN) // see RQ1
    |-> busOut.trdyN ##1 !busOut.ctlOe) else $error("control lines not released");
  a_no_claim: assert property (addrPhase && (busIn.cbeN inside {`PTSP_CMD_INTACK, // see RQ17
    `PTSP_CMD_SPECIAL, `PTSP_CMD_RSVD4}) |=> !busOut.ctlOe && busOut.devselN)
    else $error("unsupported command claimed");
  a_cfg_claim: assert property (addrPhase && busIn.idsel && busIn.ad[1:0] == 2'h0 // see RQ19
    && busIn.cbeN == `PTSP_CMD_CFGRD |=> !busOut.devselN ##1 !busOut.trdyN)
    else $error("configuration read not claimed");
  a_wr_capture: assert property (sWrDone |=> wrOut.strobe // see RQ14
    && wrOut.data == $past(busIn.ad)) else $error("write word not captured");
  a_rd_valid: assert property (!busOut.trdyN && s.isRead |-> busOut.adOe) // see RQ13
    else $error("read data not driven with target ready");

endmodule : ptsp_target

// >>> hdl/ptsp_defines.svh
// Constants for the expansion-bus target: command codes, address step, reset values.
// Assumes inclusion by bare name from the package and the target module.
`ifndef PTSP_DEFINES_SVH
`define PTSP_DEFINES_SVH

// Bus command codes on the command/byte-enable lines
`define PTSP_CMD_INTACK  4'h0
`define PTSP_CMD_SPECIAL 4'h1
`define PTSP_CMD_IORD    4'h2
`define PTSP_CMD_IOWR    4'h3
`define PTSP_CMD_RSVD4   4'h4
`define PTSP_CMD_MEMRD   4'h6
`define PTSP_CMD_MEMWR   4'h7
`define PTSP_CMD_CFGRD   4'ha
`define PTSP_CMD_CFGWR   4'hb

// Burst address step of one DWORD
`define PTSP_ADDR_STEP   32'h0000_0004
// Low address bits that must be zero for a type-0 configuration access
`define PTSP_CFG_TYPE0   2'h0

// Reset values of the sampled frame line and of driven strobes
`define PTSP_RST_HIGH    1'h1
`define PTSP_RST_LOW     1'h0
`define PTSP_RST_WORD    32'h0000_0000

`endif

// >>> hdl/ptsp_pkg.sv
// Types shared by the expansion-bus target and its surroundings.
// Assumes ptsp_defines.svh is on the include path.
package ptsp_pkg;
  `include "ptsp_defines.svh"

  // Bus steps, one bit flipping per step except TURN back to IDLE; 2'b10 is illegal
  typedef enum logic [1:0] {
    PTSP_IDLE = 2'b00,
    PTSP_DATA = 2'b01,
    PTSP_TURN = 2'b11
  } ptsp_step_t;

  // Parity-error line phases
  typedef enum logic [1:0] {
    PTSP_PERR_OFF  = 2'b00,
    PTSP_PERR_LOW  = 2'b01,
    PTSP_PERR_HIGH = 2'b11
  } ptsp_perr_t;

  // Sampled bus inputs (active-low lines keep the N suffix)
  typedef struct packed {
    logic        frameN;
    logic        irdyN;
    logic [3:0]  cbeN;
    logic        idsel;
    logic [31:0] ad;
    logic        par;
  } ptsp_bus_in_t;

  // Driven bus outputs with enables, high while driving
  typedef struct packed {
    logic [31:0] ad;
    logic        adOe;
    logic        par;
    logic        parOe;
    logic        trdyN;
    logic        devselN;
    logic        stopN;
    logic        ctlOe;
    logic        perrN;
    logic        perrOe;
    logic        serrN;
    logic        serrOe;
  } ptsp_bus_out_t;

  // Write transfer towards the user side
  typedef struct packed {
    logic        strobe;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
    logic [3:0]  cmd;
  } ptsp_wr_t;

  // Whole state of the target
  typedef struct packed {
    ptsp_step_t  step;
    ptsp_perr_t  perr;
    logic        frameQ;
    logic        ready;
    logic        isRead;
    logic        special;
    logic        chkAddr;
    logic        chkData;
    logic        chkSpec;
    logic        calcPar;
    logic        serrOe;
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [31:0] adOut;
    logic        adOe;
    logic        parOut;
    logic        parOe;
    logic        trdyN;
    logic        devselN;
    logic        ctlOe;
    ptsp_wr_t    wr;
  } ptsp_state_t;
endpackage : ptsp_pkg

// >>> dv/ptsp_master.sv
// Bus master model: one-word transactions on the expansion bus.
// Assumes the target's outputs are registered on the rising clock edge.
`timescale 1ns/100ps

module ptsp_master
  import ptsp_pkg::*;
(
  // Clock
  input  wire logic          clk,
  // Bus lines
  input  wire ptsp_bus_out_t busOut,
  output      ptsp_bus_in_t  busIn
);
  logic        frameN = 1'h1;
  logic        irdyN  = 1'h1;
  logic [3:0]  cbeN   = 4'hf;
  logic        idsel  = 1'h0;
  logic [31:0] ad     = 32'h0;
  logic        adOe   = 1'h0;
  logic        par    = 1'h0;
  logic        parOe  = 1'h0;
  logic        trdyWire;

  // Target ready on the wire; the pull-up holds it high when released
  assign trdyWire = busOut.ctlOe ? busOut.trdyN : 1'h1;

  // Wire levels; a released line shows the inverse of the last value
  assign busIn = {frameN, irdyN, cbeN, idsel,
                  busOut.adOe ? busOut.ad : (adOe ? ad : ~ad),
                  busOut.parOe ? busOut.par : (parOe ? par : ~par)};

  // One transaction; bad[0] spoils address parity, bad[1] data parity
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr,
                      input logic [31:0] data, input logic [3:0] be, input logic sel,
                      input logic [1:0] bad, output logic [31:0] rd, output logic done);
    int n;
    rd = 32'h0;
    @(posedge clk);
    frameN <= 1'h0;
    cbeN   <= cmd;
    idsel  <= sel;
    ad     <= addr;
    adOe   <= 1'h1;
    // Single data phase: frame rises as initiator ready falls
    @(posedge clk);
    frameN <= 1'h1;
    irdyN  <= 1'h0;
    cbeN   <= ~be;
    idsel  <= 1'h0;
    ad     <= data;
    adOe   <= cmd[0];
    par    <= ^{addr, cmd} ^ bad[0];
    parOe  <= 1'h1;
    // Write parity one clock after initiator ready, held to the end
    @(posedge clk);
    par    <= ^{data, ~be} ^ bad[1];
    parOe  <= cmd[0];
    for (n = 0; n < 6; n++)
    begin
      @(negedge clk);
      rd = busIn.ad;
      if (trdyWire === 1'h0)
        break;
    end
    done = (n < 6);
    // Transfer edge, or give up on a silent target
    @(posedge clk);
    irdyN  <= 1'h1;
    adOe   <= 1'h0;
    cbeN   <= 4'hf;
    @(posedge clk);
    parOe  <= 1'h0;
  endtask : xfer
endmodule : ptsp_master

// >>> dv/test_pci_target_signalling_parity.sv
// Testbench for the expansion-bus target, driven by the master model.
// Assumes the package, the target and the master model compile first.
`timescale 1ns/100ps
`include "ptsp_defines.svh"

module test_pci_target_signalling_parity;
  import ptsp_pkg::*;
  localparam logic [31:0] IOB  = 32'h0000_03c0;
  localparam logic [31:0] MEMB = 32'hf000_0000;
  logic          clk    = 1'h0;
  logic          rstn   = 1'h0;
  logic          ce     = 1'h1;
  logic [31:0]   rdData = 32'h0;
  ptsp_bus_in_t  busIn;
  ptsp_bus_out_t busOut;
  logic          rdReq;
  logic [31:0]   rdAddr;
  logic [3:0]    rdCmd;
  logic [3:0]    rc;
  ptsp_wr_t      wrOut;
  ptsp_bus_out_t hist [10];
  logic          stb [10];
  logic [31:0]   rdBack, ra, nSerr;
  logic          claimed, anyPerr, anyCtl, serrHi;
  int            bad_count = 0;
  int            n_tests = 0;

  ptsp_target #(.IO_BASE(IOB), .IO_MASK(32'hffff_fff0), .MEM_BASE(MEMB),
                .MEM_MASK(32'hff00_0000))
    u_dut (.clk(clk), .rstn(rstn), .ce(ce), .busIn(busIn), .busOut(busOut), .rdReq(rdReq),
           .rdAddr(rdAddr), .rdCmd(rdCmd), .rdData(rdData), .wrOut(wrOut));
  ptsp_master u_mst (.clk(clk), .busOut(busOut), .busIn(busIn));

  // 125 MHz clock
  initial
  begin
    forever #4 clk = ~clk;
  end

  // Word and flag compares
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask : chkb

  // One transaction, recording the target's outputs cycle by cycle
  task automatic run(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] data,
                     input logic [3:0] be, input logic sel, input logic [1:0] bad);
    nSerr = 32'h0;
    anyPerr = 1'h0;
    anyCtl = 1'h0;
    serrHi = 1'h0;
    fork
      u_mst.xfer(cmd, addr, data, be, sel, bad, rdBack, claimed);
      begin
        @(posedge clk);
        for (int k = 0; k < 10; k++)
        begin
          @(negedge clk);
          hist[k] = busOut;
          stb[k] = wrOut.strobe;
          nSerr += {31'h0, busOut.serrOe};
          anyPerr |= busOut.perrOe;
          anyCtl |= busOut.ctlOe;
          serrHi |= busOut.serrOe & busOut.serrN;
          if (k == 1)
          begin
            ra = rdReq ? rdAddr : 32'hx;
            rc = rdCmd;
          end
        end
      end
    join
    @(posedge clk);
  endtask : run

  task automatic t_io_write();
    run(`PTSP_CMD_IOWR, IOB + 32'h1, 32'ha1b2_c3d4, 4'h6, 1'h0, 2'h0);
    chkb("devsel", 1'h0, hist[1].devselN);
    chkb("trdy", 1'h0, hist[2].trdyN);
    chkb("stop", 1'h1, hist[2].stopN);
    chk("wr cmd", 32'h3, {28'h0, wrOut.cmd});
    chkb("strobe", 1'h1, stb[3]);
    chk("wr addr", IOB + 32'h1, wrOut.addr);
    chk("wr data", 32'ha1b2_c3d4, wrOut.data);
    chk("wr be", 32'h6, {28'h0, wrOut.be});
    chkb("turn high", 1'h1, hist[3].devselN & hist[3].ctlOe);
    chkb("released", 1'h0, hist[4].ctlOe);
    chkb("no perr", 1'h0, anyPerr);
    $display("t_io_write done");
  endtask : t_io_write

  task automatic t_mem_read();
    @(posedge clk);
    rdData <= 32'h5a0f_3c96;
    run(`PTSP_CMD_MEMRD, MEMB + 32'h8, 32'h0, 4'hf, 1'h0, 2'h0);
    chkb("claimed", 1'h1, claimed);
    chk("rd addr", MEMB + 32'h8, ra);
    chk("rd cmd", 32'h6, {28'h0, rc});
    chk("rd data", 32'h5a0f_3c96, rdBack);
    chkb("ad oe", 1'h1, hist[2].adOe);
    chkb("rd par", ^{32'h5a0f_3c96, 4'h0}, hist[3].par);
    chkb("par oe", 1'h1, hist[3].parOe);
    chkb("par off", 1'h0, hist[4].parOe);
    $display("t_mem_read done");
  endtask : t_mem_read

  task automatic t_cfg();
    for (int i = 0; i < 4; i++)
    begin
      run(i[1] ? `PTSP_CMD_CFGWR : `PTSP_CMD_CFGRD, 32'h10, 32'h1, 4'hf, i[0], 2'h0);
      chkb("cfg claim", i[0], claimed);
    end
    $display("t_cfg done");
  endtask : t_cfg

  task automatic t_refuse();
    logic [3:0] cmds [3] = '{`PTSP_CMD_INTACK, `PTSP_CMD_SPECIAL, `PTSP_CMD_RSVD4};
    foreach (cmds[i])
    begin
      run(cmds[i], IOB, 32'h0, 4'hf, 1'h1, 2'h0);
      chkb("unclaimed", 1'h0, claimed | anyCtl);
      chk("no serr", 32'h0, nSerr);
    end
    $display("t_refuse done");
  endtask : t_refuse

  task automatic t_parity();
    run(`PTSP_CMD_MEMWR, MEMB, 32'h0123_4567, 4'hf, 1'h0, 2'h2);
    chkb("perr low", 1'h0, hist[4].perrN | ~hist[4].perrOe);
    chkb("perr high", 1'h1, hist[5].perrN & hist[5].perrOe);
    chkb("perr off", 1'h0, hist[6].perrOe);
    chk("wr no serr", 32'h0, nSerr);
    run(`PTSP_CMD_MEMWR, 32'h1000_0000, 32'h0123_4567, 4'hf, 1'h0, 2'h2);
    chkb("miss perr", 1'h0, anyPerr);
    run(`PTSP_CMD_IOWR, IOB, 32'h0, 4'hf, 1'h0, 2'h1);
    chk("addr serr", 32'h1, nSerr);
    chkb("serr high", 1'h0, serrHi);
    run(`PTSP_CMD_SPECIAL, 32'h0, 32'h0, 4'hf, 1'h0, 2'h2);
    chkb("spec serr", 1'h1, nSerr != 32'h0);
    chkb("spec perr", 1'h0, anyPerr);
    $display("t_parity done");
  endtask : t_parity

  // Counts and verdict
  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  // Reset for four cycles, then the scenarios
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    t_io_write();
    t_mem_read();
    t_cfg();
    t_refuse();
    t_parity();
    test_done();
  end
endmodule : test_pci_target_signalling_parity
